/* pkg/mmct_pkg.sv */
/*
 * Shared constants and types of the meter mode control and timing block.
 * Assumes a single oscillator clock feeding the block and an APB master.
 */
`default_nettype none
package mmct_pkg;
    localparam int unsigned EOC_CYCLES   = 10;     // End pulse, osc cycles
    localparam int unsigned CONV_DIV     = 2;      // Converter clock divide
    localparam int unsigned BUZ_DIV      = 8;      // Buzzer divide
    localparam int unsigned BP_DIV       = 240;    // Backplane divide
    localparam int unsigned GATE_CYCLES  = 40000;  // Counter time base
    localparam int unsigned INT_FULL     = 2000;   // Integrate counts
    localparam int unsigned RANGE_FACTOR = 10;     // Range shortening
    localparam int unsigned INT_RANGE    = INT_FULL / RANGE_FACTOR;
    localparam int unsigned AZ_COUNTS    = 1000;   // Auto-zero counts
    localparam int unsigned FULL_SCALE   = 3999;   // Largest reading
    localparam int unsigned DEINT_MAX    = FULL_SCALE + 1;
    localparam int unsigned UNDER_LIMIT  = 380;    // Under-range bound
    localparam int unsigned DECADE       = 10;     // Auto-range step
    localparam int unsigned RANGE_LOW    = 4000;   // Below: three places
    localparam int unsigned VAL_W        = 16;     // Reading width
    localparam int unsigned CNT_W        = 24;     // Pulse count width
    localparam logic [7:0]  OFS_CTRL     = 8'h00;  // Control register
    localparam logic [7:0]  OFS_STATUS   = 8'h04;  // Status register
    localparam logic [7:0]  OFS_RESULT   = 8'h08;  // Reading register
    localparam int unsigned CTRL_HOLD    = 0;      // Software hold bit
    localparam int unsigned ST_OVER      = 0;      // Status: over-range
    localparam int unsigned ST_UNDER     = 1;      // Status: under-range
    localparam int unsigned ST_MODE      = 2;      // Status: mode, 2 bits
    localparam int unsigned ST_PHASE     = 4;      // Status: phase, 2 bits
    localparam logic [1:0]  PTS_NONE     = 2'h0;   // No decimal point
    localparam logic [1:0]  PTS_ONE      = 2'h1;   // One place
    localparam logic [1:0]  PTS_TWO      = 2'h2;   // Two places
    localparam logic [1:0]  PTS_THREE    = 2'h3;   // Three places

    // Operating modes
    typedef enum logic [1:0] {MODE_ADC, MODE_ADC_X10, MODE_COUNT,
                              MODE_PROBE} mmct_mode_e;
    // Converter phases
    typedef enum logic [1:0] {PH_AUTOZERO, PH_INTEG, PH_DEINT,
                              PH_EOC} mmct_phase_e;
    // What the display shows
    typedef struct packed {
        logic [VAL_W-1:0] value;     // Digits as a count
        logic [1:0]       places;    // Decimal places
        logic             points_on; // Points visible
        logic             overload;  // Overload pattern shown
    } mmct_disp_s;
endpackage
`default_nettype wire

/* rtl/mmct_meter_core.sv */
/*
 * Mode decode, display control and timing of a dual-slope metering
 * converter with frequency counter and logic probe. Assumes the inputs
 * are synchronous to clk_i (the oscillator) except the pulse input,
 * which is synchronised here, and an APB master on the register side.
 */
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module mmct_meter_core #(
    parameter int unsigned GATE_CYCLES = mmct_pkg::GATE_CYCLES // Time base
) (
    input  wire logic                clk_i,          // Oscillator clock
    input  wire logic                reset_i,        // Async reset, high
    input  wire logic                probe_select_i, // Logic probe mode
    input  wire logic                measure_select_i, // High: counter
    input  wire logic                range_or_pulse_input_i, // Range/pulses
    input  wire logic                point0_low_probe_i,  // Point 0 / low
    input  wire logic                point1_high_probe_i, // Point 1 / high
    input  wire logic                buzzer_request_i, // Buzzer request
    input  wire logic                comparator_i,   // Integrator above 0
    input  wire logic                eoc_hold_i,     // End/hold pin level
    output logic                     eoc_hold_o,     // End/hold pin drive
    output logic                     eoc_hold_oe_o,  // End/hold drive on
    output mmct_pkg::mmct_disp_s     disp_o,         // Display content
    output logic                     high_annunc_o,  // High annunciator
    output logic                     low_annunc_o,   // Low annunciator
    output logic                     buzzer_o,       // Buzzer square wave
    output logic                     backplane_o,    // Backplane clock
    output logic                     pulldown_en_o,  // Point pull-downs on
    output logic                     over_range_o,   // Over-range flag
    output logic                     under_range_flag_o, // Under-range
    output mmct_pkg::mmct_phase_e    phase_o,        // Converter phase
    input  wire logic                psel,           // APB select
    input  wire logic                penable,        // APB enable
    input  wire logic                pwrite,         // APB write
    input  wire logic [7:0]          paddr,          // APB byte address
    input  wire logic [31:0]         pwdata,         // APB write data
    output logic                     pready,         // APB ready
    output logic [31:0]              prdata,         // APB read data
    output logic                     pslverr         // APB error
);
    // Refuse a gate too short to hold an end pulse
    if (GATE_CYCLES <= mmct_pkg::EOC_CYCLES) begin : gate_check
        $error("GATE_CYCLES too small");
    end

    localparam int unsigned BUZ_HALF = mmct_pkg::BUZ_DIV / 2;
    localparam int unsigned BP_HALF  = mmct_pkg::BP_DIV / 2;
    localparam logic [mmct_pkg::CNT_W-1:0] R1_LIM =
        mmct_pkg::CNT_W'(mmct_pkg::RANGE_LOW);
    localparam logic [mmct_pkg::CNT_W-1:0] R2_LIM =
        mmct_pkg::CNT_W'(mmct_pkg::RANGE_LOW * mmct_pkg::DECADE);
    localparam logic [mmct_pkg::CNT_W-1:0] R3_LIM =
        mmct_pkg::CNT_W'(mmct_pkg::RANGE_LOW * mmct_pkg::DECADE
                         * mmct_pkg::DECADE);

    // Auto-range a gate count into a reading and point position
    function automatic mmct_pkg::mmct_disp_s autorange(
        input logic [mmct_pkg::CNT_W-1:0] cnt
    );
        mmct_pkg::mmct_disp_s d;
        logic [mmct_pkg::CNT_W-1:0] v;
        d = '0;
        d.points_on = 1'b1;
        if (cnt < R1_LIM)
        begin
            v = cnt;
            d.places = mmct_pkg::PTS_THREE;
        end
        else if (cnt < R2_LIM)
        begin
            v = cnt / mmct_pkg::CNT_W'(mmct_pkg::DECADE);
            d.places = mmct_pkg::PTS_TWO;
        end
        else if (cnt < R3_LIM)
        begin
            v = cnt / mmct_pkg::CNT_W'(mmct_pkg::DECADE * mmct_pkg::DECADE);
            d.places = mmct_pkg::PTS_ONE;
        end
        else
        begin
            v = cnt / mmct_pkg::CNT_W'(mmct_pkg::DECADE * mmct_pkg::DECADE
                                        * mmct_pkg::DECADE);
            d.places = mmct_pkg::PTS_NONE;
        end
        d.value = v[mmct_pkg::VAL_W-1:0];
        return d;
    endfunction

    mmct_pkg::mmct_mode_e         mode;          // Decoded mode
    logic                         probe_on;      // Probe mode active
    logic                         conv_en;       // Oscillator over two
    logic                         conv_div_r;    // Converter divider
    logic [7:0]                   buz_cnt_r;     // Buzzer divider
    logic [7:0]                   bp_cnt_r;      // Backplane divider
    logic [15:0]                  phase_cnt_r;   // Phase count
    logic [3:0]                   eoc_cnt_r;     // End pulse length
    logic [mmct_pkg::VAL_W-1:0]   adc_val_r;     // Last conversion
    logic                         adc_done;      // Conversion finished
    logic [31:0]                  gate_cnt_r;    // Gate window timer
    logic [mmct_pkg::CNT_W-1:0]   pulse_cnt_r;   // Pulses this gate
    logic [mmct_pkg::CNT_W-1:0]   pulse_res_r;   // Pulses last gate
    logic                         gate_end;      // Gate closes
    logic [2:0]                   pls_sync_r;    // Pulse synchroniser
    logic                         hold_sw_r;     // Software hold
    logic                         eoc_start;     // Start of end pulse
    logic                         eoc_last;      // Last pulse cycle
    logic                         count_mode;    // Counter selected
    mmct_pkg::mmct_disp_s         new_disp;      // Reading to latch
    logic [15:0]                  int_len;       // Integrate length

    // Mode decode: probe overrides, then measure select, then range
    always_comb
    begin
        if (probe_select_i)
            mode = mmct_pkg::MODE_PROBE;
        else if (measure_select_i)
            mode = mmct_pkg::MODE_COUNT;
        else if (range_or_pulse_input_i)
            mode = mmct_pkg::MODE_ADC_X10;
        else
            mode = mmct_pkg::MODE_ADC;
    end
    assign probe_on   = (mode == mmct_pkg::MODE_PROBE);
    assign count_mode = measure_select_i;
    assign conv_en    = conv_div_r;
    assign int_len    = (mode == mmct_pkg::MODE_ADC_X10)
                      ? 16'(mmct_pkg::INT_RANGE)
                      : 16'(mmct_pkg::INT_FULL);

    // Converter clock enable, every second oscillator cycle
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            conv_div_r <= 1'b0;
        else
            conv_div_r <= ~conv_div_r;
    end

    // Buzzer square wave, on by request or low probe
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            buz_cnt_r <= 8'h00;
            buzzer_o  <= 1'b0;
        end
        else if (buz_cnt_r == 8'(BUZ_HALF - 1))
        begin
            buz_cnt_r <= 8'h00;
            if (buzzer_request_i ||
                (probe_on && point0_low_probe_i))
                buzzer_o <= ~buzzer_o;
            else
                buzzer_o <= 1'b0;
        end
        else
            buz_cnt_r <= buz_cnt_r + 8'h01;
    end

    // Backplane clock, oscillator over 240
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            bp_cnt_r    <= 8'h00;
            backplane_o <= 1'b0;
        end
        else if (bp_cnt_r == 8'(BP_HALF - 1))
        begin
            bp_cnt_r    <= 8'h00;
            backplane_o <= ~backplane_o;
        end
        else
            bp_cnt_r <= bp_cnt_r + 8'h01;
    end

    // Dual-slope sequence; probe mode pins it in auto-zero
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            phase_o     <= mmct_pkg::PH_AUTOZERO;
            phase_cnt_r <= 16'h0000;
            adc_val_r   <= '0;
        end
        else if (probe_on && !count_mode)
        begin
            phase_o     <= mmct_pkg::PH_AUTOZERO;
            phase_cnt_r <= 16'h0000;
        end
        else if (count_mode)
        begin
            phase_o     <= mmct_pkg::PH_AUTOZERO;         // Idle in counter
            phase_cnt_r <= 16'h0000;
        end
        else if (phase_o == mmct_pkg::PH_EOC)
        begin
            if (eoc_last)
                phase_o <= mmct_pkg::PH_AUTOZERO;
        end
        else if (conv_en)
        begin
            case (phase_o)
                mmct_pkg::PH_AUTOZERO:
                    if (phase_cnt_r == 16'(mmct_pkg::AZ_COUNTS - 1))
                    begin
                        phase_o     <= mmct_pkg::PH_INTEG;
                        phase_cnt_r <= 16'h0000;
                    end
                    else
                        phase_cnt_r <= phase_cnt_r + 16'h0001;
                mmct_pkg::PH_INTEG:
                    if (phase_cnt_r == int_len - 16'h0001)
                    begin
                        phase_o     <= mmct_pkg::PH_DEINT;
                        phase_cnt_r <= 16'h0000;
                    end
                    else
                        phase_cnt_r <= phase_cnt_r + 16'h0001;
                mmct_pkg::PH_DEINT:
                    // Zero crossing or full-scale overflow ends it
                    if (!comparator_i ||
                        phase_cnt_r == 16'(mmct_pkg::DEINT_MAX))
                    begin
                        adc_val_r   <= phase_cnt_r[mmct_pkg::VAL_W-1:0];
                        phase_o     <= mmct_pkg::PH_EOC;
                        phase_cnt_r <= 16'h0000;
                    end
                    else
                        phase_cnt_r <= phase_cnt_r + 16'h0001;
                default:
                    phase_o <= mmct_pkg::PH_AUTOZERO;
            endcase
        end
    end
    assign adc_done = conv_en && !count_mode && !probe_on
                   && (phase_o == mmct_pkg::PH_DEINT)
                   && (!comparator_i ||
                       phase_cnt_r == 16'(mmct_pkg::DEINT_MAX));

    // Pulse input synchroniser, only the later stages are compared
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            pls_sync_r <= 3'h0;
        else
            pls_sync_r <= {pls_sync_r[1:0], range_or_pulse_input_i};
    end

    // Gate window and rising-edge counter, also during probe mode
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            gate_cnt_r  <= 32'h0000_0000;
            pulse_cnt_r <= '0;
            pulse_res_r <= '0;
        end
        else if (!count_mode)
        begin
            gate_cnt_r  <= 32'h0000_0000;
            pulse_cnt_r <= '0;
        end
        else if (gate_end)
        begin
            gate_cnt_r  <= 32'h0000_0000;
            pulse_res_r <= pulse_cnt_r;
            pulse_cnt_r <= '0;
        end
        else
        begin
            gate_cnt_r <= gate_cnt_r + 32'h0000_0001;
            if (pls_sync_r[1] && !pls_sync_r[2])
                pulse_cnt_r <= pulse_cnt_r
                             + mmct_pkg::CNT_W'(1);
        end
    end
    assign gate_end = count_mode
                   && (gate_cnt_r == 32'(GATE_CYCLES - 1));

    // End pulse, driven low for ten oscillator cycles
    assign eoc_start = adc_done || gate_end;
    assign eoc_last  = (eoc_cnt_r == 4'h1);
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            eoc_cnt_r     <= 4'h0;
            eoc_hold_o    <= 1'b1;
            eoc_hold_oe_o <= 1'b1;
        end
        else if (eoc_start)
        begin
            eoc_cnt_r  <= 4'(mmct_pkg::EOC_CYCLES);
            eoc_hold_o <= 1'b0;
        end
        else if (eoc_cnt_r != 4'h0)
        begin
            eoc_cnt_r <= eoc_cnt_r - 4'h1;
            if (eoc_last)
                eoc_hold_o <= 1'b1;
        end
    end

    // Reading to latch for the active mode
    always_comb
    begin
        if (count_mode)
            new_disp = autorange(pulse_res_r);
        else
        begin
            new_disp = '0;
            new_disp.value     = adc_val_r;
            new_disp.points_on = 1'b1;
            new_disp.places    = {point1_high_probe_i,
                                  point0_low_probe_i};
        end
        if (new_disp.value > mmct_pkg::VAL_W'(mmct_pkg::FULL_SCALE))
            new_disp.overload = 1'b1;
        if (probe_on)
        begin
            new_disp.overload = 1'b1;
            if (!count_mode)
                new_disp.points_on = 1'b0;
        end
    end

    // Display latch at the end pulse unless held
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            disp_o             <= '0;
            over_range_o       <= 1'b0;
            under_range_flag_o <= 1'b0;
        end
        else if (eoc_last && !eoc_hold_i && !hold_sw_r)
        begin
            disp_o       <= new_disp;
            over_range_o <= new_disp.value
                          > mmct_pkg::VAL_W'(mmct_pkg::FULL_SCALE);
            under_range_flag_o <= new_disp.value
                          <= mmct_pkg::VAL_W'(mmct_pkg::UNDER_LIMIT);
        end
        else if (probe_on)
        begin
            disp_o.overload <= 1'b1;
            if (!count_mode)
                disp_o.points_on <= 1'b0;
        end
        else if (!new_disp.overload && !over_range_o)
            disp_o.overload <= 1'b0;
    end

    // Probe annunciators and pull-down control, unlatched
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            high_annunc_o <= 1'b0;
            low_annunc_o  <= 1'b0;
            pulldown_en_o <= 1'b1;
        end
        else
        begin
            high_annunc_o <= probe_on && point1_high_probe_i;
            low_annunc_o  <= probe_on && point0_low_probe_i;
            pulldown_en_o <= !probe_on;
        end
    end

    // APB slave: ready in the first access cycle, zero wait states
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            pready    <= 1'b0;
            prdata    <= 32'h0000_0000;
            pslverr   <= 1'b0;
            hold_sw_r <= 1'b0;
        end
        else if (psel && !penable)
        begin
            pready  <= 1'b1;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
            case (paddr)
                mmct_pkg::OFS_CTRL:
                    prdata[mmct_pkg::CTRL_HOLD] <= hold_sw_r;
                mmct_pkg::OFS_STATUS:
                begin
                    prdata[mmct_pkg::ST_OVER]  <= over_range_o;
                    prdata[mmct_pkg::ST_UNDER] <= under_range_flag_o;
                    prdata[mmct_pkg::ST_MODE +: 2]  <= mode;
                    prdata[mmct_pkg::ST_PHASE +: 2] <= phase_o;
                end
                mmct_pkg::OFS_RESULT:
                    prdata[mmct_pkg::VAL_W-1:0] <= disp_o.value;
                default:
                    pslverr <= 1'b1;                      // Unmapped
            endcase
        end
        else
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            if (psel && penable && pready && pwrite
                && paddr == mmct_pkg::OFS_CTRL)
                hold_sw_r <= pwdata[mmct_pkg::CTRL_HOLD];
        end
    end
endmodule
`default_nettype wire

/* verif/mmct_chk_assertions.sv */
/* Port checker of the meter core.
   Bound to mmct_meter_core; one oscillator clock, async reset. */
`timescale 1ns/100ps
`default_nettype none
module mmct_chk (
    input wire logic                 clk_i,              // Oscillator
    input wire logic                 reset_i,            // Reset
    input wire logic                 probe_select_i,     // Probe mode
    input wire logic                 point0_low_probe_i, // Low probe
    input wire logic                 point1_high_probe_i, // High probe
    input wire logic                 buzzer_request_i,   // Buzzer ask
    input wire logic                 eoc_hold_i,         // Pin level
    input wire logic                 eoc_hold_o,         // Pin drive
    input wire mmct_pkg::mmct_disp_s disp_o,             // Display
    input wire logic                 high_annunc_o,      // High lamp
    input wire logic                 low_annunc_o,       // Low lamp
    input wire logic                 buzzer_o,           // Buzzer
    input wire logic                 pulldown_en_o,      // Pull-downs
    input wire logic                 over_range_o,       // Over flag
    input wire logic                 under_range_flag_o  // Under flag
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    property p_high; // High lamp tracks its probe
        probe_select_i |=> high_annunc_o == $past(point1_high_probe_i);
    endproperty
    a_high: assert property (p_high) else $error("high lamp wrong");
    property p_low; // Low probe lights lamp and buzzer
        (probe_select_i && point0_low_probe_i |=> low_annunc_o) and
        ((probe_select_i && point0_low_probe_i) [*8] |=>
            buzzer_o || $past(buzzer_o, 4));
    endproperty
    a_low: assert property (p_low) else $error("low lamp wrong");
    property p_pull; // Pull-downs off in probe mode
        probe_select_i [*2] |-> !pulldown_en_o;
    endproperty
    a_pull: assert property (p_pull) else $error("pull-down on");
    property p_buz; // Requested buzzer never stays quiet
        not (buzzer_request_i && !buzzer_o) [*7];
    endproperty
    a_buz: assert property (p_buz) else $error("buzzer silent");
    property p_eoc; // End pulse lasts exactly ten cycles
        $fell(eoc_hold_o) |-> (!eoc_hold_o) [*8] ##1 (!eoc_hold_o) [*2]
            ##1 eoc_hold_o;
    endproperty
    a_eoc: assert property (p_eoc) else $error("end pulse length");
    property p_hold; // Pin held high freezes display
        (!probe_select_i && eoc_hold_i) [*3] |-> $stable(disp_o);
    endproperty
    a_hold: assert property (p_hold) else $error("display moved");
    property p_over; // Over flag matches new reading
        !probe_select_i && $changed(disp_o.value) |->
            over_range_o == (disp_o.value > mmct_pkg::FULL_SCALE);
    endproperty
    a_over: assert property (p_over) else $error("over flag");
    property p_under; // Under flag matches new reading
        !probe_select_i && $changed(disp_o.value) |->
            under_range_flag_o == (disp_o.value <= mmct_pkg::UNDER_LIMIT);
    endproperty
    a_under: assert property (p_under) else $error("under flag");
endmodule
bind mmct_meter_core mmct_chk i_mmct_chk (
    .clk_i(clk_i), .reset_i(reset_i), .probe_select_i(probe_select_i),
    .point0_low_probe_i(point0_low_probe_i),
    .point1_high_probe_i(point1_high_probe_i),
    .buzzer_request_i(buzzer_request_i), .eoc_hold_i(eoc_hold_i),
    .eoc_hold_o(eoc_hold_o), .disp_o(disp_o),
    .high_annunc_o(high_annunc_o), .low_annunc_o(low_annunc_o),
    .buzzer_o(buzzer_o), .pulldown_en_o(pulldown_en_o),
    .over_range_o(over_range_o),
    .under_range_flag_o(under_range_flag_o));
`default_nettype wire

/* verif/mmct_far.sv */
/* Far side: pulse source and hold switch on the end/hold pin.
   Assumes clk_i is the oscillator; run_i low at time zero. */
`timescale 1ns/100ps
`default_nettype none
module mmct_far (
    input  wire logic clk_i,   // Oscillator
    input  wire logic run_i,   // Pulses on
    input  wire logic hold_i,  // Hold switch closed
    input  wire logic oe_i,    // Device drive enable
    input  wire logic drv_i,   // Device weak drive
    output logic      pulse_o, // Pulse train
    output logic      pin_o    // Resolved pin level
);
    logic [2:0] div_r; // Half-period count
    // Square wave of ten clocks, low when stopped
    always_ff @(posedge clk_i)
    begin
        div_r <= (div_r >= 3'h4 || !run_i) ? 3'h0 : div_r + 3'h1;
        pulse_o <= run_i & (pulse_o ^ (div_r == 3'h4));
    end
    // Switch overpowers weak drive; undriven pin idles high
    assign pin_o = hold_i | !oe_i | drv_i;
endmodule
`default_nettype wire

/* verif/tb_top.sv */
/* Bench of the meter core: mode table, dividers, APB, conversions.
   Assumes the far-side model and bound checker are compiled first. */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic clk_i = 1'h0, reset_i = 1'h1, cmp = 1'h0, run = 1'h0, hold = 1'h0;
    logic probe = 1'h0, meas = 1'h0, rng = 1'h0, p0 = 1'h0, p1 = 1'h0;
    logic breq = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic pulse, pin, eo, oe, pready, pslverr, er, hi, lo, bz, bp, pd;
    logic ovr, und;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    mmct_pkg::mmct_disp_s disp, snap;
    mmct_pkg::mmct_phase_e ph;
    int checks = 0, n_mismatch = 0, n, m, k;
    wire logic rin = rng | (run & pulse);
    // Rows: probe meas range p1 p0 | mode | high low pull-down
    logic [9:0] rows [6] = '{10'h061, 10'h089, 10'h111, 10'h25C, 10'h3BA,
                             10'h27E};
    mmct_meter_core #(.GATE_CYCLES(200)) i_mmct_meter_core (
        .clk_i(clk_i), .reset_i(reset_i), .probe_select_i(probe),
        .measure_select_i(meas), .range_or_pulse_input_i(rin),
        .point0_low_probe_i(p0), .point1_high_probe_i(p1),
        .buzzer_request_i(breq), .comparator_i(cmp), .eoc_hold_i(pin),
        .eoc_hold_o(eo), .eoc_hold_oe_o(oe), .disp_o(disp),
        .high_annunc_o(hi), .low_annunc_o(lo), .buzzer_o(bz),
        .backplane_o(bp), .pulldown_en_o(pd), .over_range_o(ovr),
        .under_range_flag_o(und), .phase_o(ph), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr));
    mmct_far i_mmct_far (.clk_i(clk_i), .run_i(run), .hold_i(hold),
        .oe_i(oe), .drv_i(eo), .pulse_o(pulse), .pin_o(pin));
    always #25 clk_i = ~clk_i;
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, e);
        checks++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("wrong value %s exp %h seen %h", nm, e, s);
        end
    endtask
    // One clock with a hang limit
    task automatic tick(inout int c);
        @(posedge clk_i);
        c++;
        if (c > 30000)
        begin
            n_mismatch++;
            final_report();
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, logic [31:0] d);
        int c = 0;
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
        @(posedge clk_i);
        penable <= 1'h1;
        do tick(c); while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'h0;
        @(posedge clk_i);
    endtask
    // One conversion; drop ends de-integration early
    task automatic conv(input logic r, input logic drop);
        int c = 0, t = 0;
        rng <= r;
        cmp <= 1'h1;
        do
        begin
            tick(c);
            t += (ph === mmct_pkg::PH_INTEG);
        end
        while (ph !== mmct_pkg::PH_DEINT);
        chk("integ", t, r ? 400 : 4000);
        repeat (100) @(posedge clk_i);
        if (drop)
            cmp <= 1'h0;
        do tick(c); while (eo !== 1'h0);
        t = 0;
        do
        begin
            tick(c);
            t++;
        end
        while (eo === 1'h0);
        chk("eoc", t, 10);
    endtask
    initial
    begin
        repeat (12) @(posedge clk_i);
        chk("pd0", pd, 1'h1);
        reset_i <= 1'h0;
        foreach (rows[i])
        begin
            {probe, meas, rng, p1, p0} <= rows[i][9:5];
            repeat (3) @(posedge clk_i);
            apb(1'h0, mmct_pkg::OFS_STATUS, 32'h0);
            chk("mode", rd[3:2], rows[i][4:3]);
            chk("hi", hi, rows[i][2]);
            chk("lo", lo, rows[i][1]);
            chk("pd", pd, rows[i][0]);
            chk("oe", oe, 1'h1);
        end
        chk("ovl", disp.overload, 1'h1);
        chk("pts", disp.points_on, 1'h0);
        chk("az", ph, mmct_pkg::PH_AUTOZERO);
        {probe, breq, n, m} <= {2'h1, 64'h0};
        repeat (9) @(posedge clk_i);
        repeat (240)
        begin
            @(posedge clk_i);
            n += (bz === 1'h1);
            m += (bp === 1'h1);
        end
        chk("buz", n, 120);
        chk("bp", m, 120);
        breq <= 1'h0;
        apb(1'h1, mmct_pkg::OFS_CTRL, 32'h1);
        apb(1'h0, mmct_pkg::OFS_CTRL, 32'h0);
        chk("ctrl", rd[0], 1'h1);
        apb(1'h1, mmct_pkg::OFS_CTRL, 32'h0);
        apb(1'h0, 8'h0C, 32'h0);
        chk("err", {er, rd[30:0]}, 32'h80000000);
        for (int r = 0; r < 2; r++)
        begin
            {p1, p0} <= {1'h1, r[0]};
            conv(r[0], 1'h1);
            chk("pl", disp.places, {1'h1, r[0]});
            chk("und", und, 1'h1);
            chk("ovr", ovr, 1'h0);
        end
        conv(1'h0, 1'h0);
        chk("ovr1", ovr, 1'h1);
        hold <= 1'h1;
        snap = disp;
        conv(1'h0, 1'h1);
        chk("held", disp, snap);
        {hold, meas, run, k} <= {3'h3, 32'h0};
        do tick(k); while (eo !== 1'h0);
        do tick(k); while (eo !== 1'h1);
        chk("cnt", disp.value inside {[19:21]}, 1'h1);
        chk("pl3", disp.places, mmct_pkg::PTS_THREE);
        apb(1'h0, mmct_pkg::OFS_RESULT, 32'h0);
        chk("res", rd inside {[19:21]}, 1'h1);
        {probe, meas} <= 2'h2;
        repeat (3) @(posedge clk_i);
        chk("pts3", disp.points_on, 1'h0);
        final_report();
    end
endmodule
`default_nettype wire
